// ===== inc/xpt_ctrl_pkg.sv
// constants and carrier types for the alternate-mode crosspoint control block
// Contract
// - four-level select strap picks control mode
// - shared clock pin: orientation or serial clock
// - shared data pin: usb control or serial data
// - pin mode: altmode control enables video lanes
// - serial mode: altmode pin ignored, register decides
// - hot plug low over 2ms kills video
// - aux pair to sideband, swapped by orientation
// - address bit from video eq strap bit0
// - address bit from downstream usb eq bit0
// - upstream eq straps pick gain, capped 11dB
// - downstream eq straps pick downstream gain
// - video eq straps pick video gain
// - operate only while enable input high
// - transmit pairs direction follows routing
// - routing covers assignments C, D and E
// - pin mode routing from two controls
// - both controls low in pin mode: shutdown
package xpt_ctrl_pkg;

    // four-level strap codes
    typedef enum logic [1:0] {
        LVL_ZERO = 2'h0,
        LVL_RES = 2'h1,
        LVL_FLOAT = 2'h2,
        LVL_ONE = 2'h3
    } strap_lvl_type;

    // control mode decoded from the select strap
    typedef enum logic [1:0] {
        MODE_PIN = 2'h0,
        MODE_TEST = 2'h1,
        MODE_SER_1V8 = 2'h3,
        MODE_SER_3V3 = 2'h2
    } ctl_mode_type;

    // lane routing, gray along off -> usb -> usb+2 -> 4 lanes
    typedef enum logic [1:0] {
        ROUTE_OFF = 2'h0,
        ROUTE_USB = 2'h1,
        ROUTE_USB_DP2 = 2'h3,
        ROUTE_DP4 = 2'h2
    } route_type;

    // all equalizer straps travel together, one four-level code per strap
    typedef struct packed {
        logic [1:0] up_usb_eq_b1;
        logic [1:0] up_usb_eq_b0;
        logic [1:0] down_usb_eq_b1;
        logic [1:0] down_usb_eq_b0;
        logic [1:0] video_eq_b1;
        logic [1:0] video_eq_b0;
    } eq_straps_type;

    // gain codes, 4 bits each
    typedef struct packed {
        logic [3:0] up_gain;
        logic [3:0] down_gain;
        logic [3:0] video_gain;
    } eq_gain_type;

    // lane enables driven toward the analog side
    typedef struct packed {
        logic [3:0] video_lane_en;
        logic up_usb_en;
        logic down_usb_en;
        logic tx_pairs_are_inputs;
        logic aux_sbu_closed;
        logic aux_swap;
    } lane_ctl_type;

    // hot plug timeout
    localparam int HPD_TIMEOUT_US = 2000;
    localparam int CLK_MHZ = 25;
    localparam int HPD_TIMEOUT_CYC = HPD_TIMEOUT_US * CLK_MHZ;

    // gain cap on upstream usb path, in tenths of dB
    localparam int UP_GAIN_MAX_DB10 = 110;
    localparam int GAIN_STEP_DB10 = 10;
    localparam logic [3:0] UP_GAIN_MAX_CODE = 4'(UP_GAIN_MAX_DB10 / GAIN_STEP_DB10);

    // address base and bit positions of the strap-driven bits
    localparam logic [6:0] ADDR_BASE = 7'h44;
    localparam int ADDR_BIT_A0 = 0;
    localparam int ADDR_BIT_A1 = 1;

    // video lane enable patterns
    localparam logic [3:0] LANES_OFF = 4'h0;
    localparam logic [3:0] LANES_ALL = 4'hf;
    localparam logic [3:0] LANES_LOW2 = 4'h3;

endpackage

// ===== core/xpt_ctrl.sv
// control logic of the alternate-mode crosspoint switch
`timescale 1ns/1ps
module xpt_ctrl #(
    parameter int HPD_TIMEOUT_CYC = xpt_ctrl_pkg::HPD_TIMEOUT_CYC
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // device enable pin
    input wire logic dev_en_i,
    // straps
    input wire logic [1:0] prog_sel_i,
    input wire xpt_ctrl_pkg::eq_straps_type eq_straps_i,
    // shared and dedicated control pins
    input wire logic orient_or_serial_clk_i,
    input wire logic usb_ctl_or_serial_data_i,
    input wire logic altmode_ctl_i,
    input wire logic hot_plug_in_i,
    // settings from the serial target's register file
    input wire logic ser_video_en_i,
    input wire logic ser_usb_en_i,
    input wire logic ser_flip_i,
    // to the serial target
    output logic serial_en_o,
    output logic serial_1v8_o,
    output logic test_mode_o,
    output logic serial_clk_o,
    output logic serial_data_o,
    output logic [6:0] target_addr_o,
    // to the analog lanes
    output xpt_ctrl_pkg::route_type route_o,
    output xpt_ctrl_pkg::lane_ctl_type lane_ctl_o,
    output xpt_ctrl_pkg::eq_gain_type eq_gain_o,
    output logic hpd_timed_out_o
);

    // overview of the data flow through this block
    // every pin and every register-file input crosses two flops first
    // the select strap and the equalizer straps are then latched once
    // latching happens on the first cycle the synced enable reads high
    // while enabled the latched copies never move, so a strap that
    // wanders on the board cannot retune a running link
    // the select strap decides between pin control and the serial target
    // pin control: shared clock pin is orientation, shared data pin is
    // the usb path control, and the altmode pin gates the video lanes
    // serial control: both shared pins go to the serial target and the
    // altmode pin is ignored; routing comes from register-file settings
    // routing is registered, one cycle after the synced inputs settle
    // lane enables are decoded from the same next-route value so route
    // and lanes change on the same edge, except video lanes on hot plug expiry
    // the hot plug timer counts synced low cycles while running
    // it saturates at the limit, so a long unplug cannot wrap it
    // on expiry only the video lanes drop; aux to sideband stays closed
    // so the sink can still talk over aux and bring hot plug back
    // a high hot plug clears the timer at once and lanes come back on
    // the next edge that sees the expiry gone
    // the address and gain outputs read only the latched straps
    // gains are a plain index of the two codes of each strap pair
    // the upstream gain is clamped rather than wrapped at its cap
    // limitation: strap codes are trusted as delivered; the analog
    // four-level slicer is outside this block
    // limitation: serial settings arrive as plain ports, the serial
    // target itself and its register file live elsewhere
    // trade-off: each output is a flop, which costs one cycle of
    // latency but keeps glitches away from the analog switches
    // latency from a pin change to route_o is three edges in all
    // latency from a pin change to the serial pass-through is three
    // enable low forces route off within four edges
    // the serial pass-through lines idle high whenever the pins are
    // not owned by the serial target, like a released bus
    // level flags for the serial target are only shown while running
    // so a disabled part never advertises a serial level
    // reset is synchronous and active low; every flop has a constant
    // reset value, and nothing leaves reset before the sync chain fills
    // first flop of each synchroniser feeds only the second one
    // the timeout length is a parameter so benches can shorten it
    // widths come from the package so the carriers stay in one place
    // clock enables only on the strap latch and the saturating timer; others run on every edge

    // timer must fit its counter and be at least one cycle
    localparam int CNT_W = $clog2(HPD_TIMEOUT_CYC + 1);
    initial begin
        if (HPD_TIMEOUT_CYC < 1) begin
            $error("hot plug timeout must be at least one cycle");
        end
    end

    // two-flop synchronisers for every pin input
    // seven single pins, the select strap, then all equalizer codes
    localparam int NSYNC = 7 + 2 + $bits(xpt_ctrl_pkg::eq_straps_type);
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;
    assign pin_raw = {dev_en_i, orient_or_serial_clk_i, usb_ctl_or_serial_data_i,
                      altmode_ctl_i, hot_plug_in_i, ser_video_en_i, ser_usb_en_i,
                      prog_sel_i, eq_straps_i};

    // first flop feeds only the second
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
        end
    end

    // synchronised views
    logic en_s;
    logic orient_s;
    logic usbctl_s;
    logic altctl_s;
    logic hpd_s;
    logic ser_vid_s;
    logic ser_usb_s;
    logic [1:0] sel_s;
    xpt_ctrl_pkg::eq_straps_type eq_s;
    assign {en_s, orient_s, usbctl_s, altctl_s, hpd_s, ser_vid_s, ser_usb_s,
            sel_s, eq_s} = sync2_reg;

    // flip from the register file is a level, but cross anyway
    logic flip1_reg;
    logic flip2_reg;
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            flip1_reg <= 1'b0;
            flip2_reg <= 1'b0;
        end else begin
            flip1_reg <= ser_flip_i;
            flip2_reg <= flip1_reg;
        end
    end

    // enable tracking; pull-down means an idle pin reads disabled
    logic en_prev_reg;
    logic run_reg;
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            en_prev_reg <= 1'b0;
            run_reg <= 1'b0;
        end else begin
            en_prev_reg <= en_s;
            run_reg <= en_s;
        end
    end

    // latch straps on the rising enable; held while running
    logic strap_take;
    logic [1:0] sel_reg;
    xpt_ctrl_pkg::eq_straps_type eq_reg;
    assign strap_take = en_s && !en_prev_reg;
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            sel_reg <= 2'h0;
            eq_reg <= '0;
        end else if (strap_take) begin
            sel_reg <= sel_s;
            eq_reg <= eq_s;
        end
    end

    // mode decode of the select strap
    xpt_ctrl_pkg::ctl_mode_type mode;
    always_comb begin
        unique case (xpt_ctrl_pkg::strap_lvl_type'(sel_reg))
            xpt_ctrl_pkg::LVL_ZERO: mode = xpt_ctrl_pkg::MODE_PIN;
            xpt_ctrl_pkg::LVL_RES: mode = xpt_ctrl_pkg::MODE_TEST;
            xpt_ctrl_pkg::LVL_FLOAT: mode = xpt_ctrl_pkg::MODE_SER_1V8;
            xpt_ctrl_pkg::LVL_ONE: mode = xpt_ctrl_pkg::MODE_SER_3V3;
        endcase
    end
    logic pin_mode;
    assign pin_mode = (mode == xpt_ctrl_pkg::MODE_PIN);

    // serial-side outputs and pin sharing
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            serial_en_o <= 1'b0;
            serial_1v8_o <= 1'b0;
            test_mode_o <= 1'b0;
            serial_clk_o <= 1'b1;
            serial_data_o <= 1'b1;
        end else begin
            serial_en_o <= run_reg && !pin_mode;
            // level flags only while running, never from a stale latch
            serial_1v8_o <= run_reg && (mode == xpt_ctrl_pkg::MODE_SER_1V8);
            test_mode_o <= run_reg && (mode == xpt_ctrl_pkg::MODE_TEST);
            // idle-high bus whenever the serial target does not own the pins
            serial_clk_o <= (run_reg && !pin_mode) ? orient_s : 1'b1;
            serial_data_o <= (run_reg && !pin_mode) ? usbctl_s : 1'b1;
        end
    end

    // address from strap bit 0 of video and downstream eq
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            target_addr_o <= xpt_ctrl_pkg::ADDR_BASE;
        end else begin
            target_addr_o <= xpt_ctrl_pkg::ADDR_BASE;
            // bit 0 of a four-level strap is taken as its low code bit
            target_addr_o[xpt_ctrl_pkg::ADDR_BIT_A1] <= eq_reg.video_eq_b0[0];
            target_addr_o[xpt_ctrl_pkg::ADDR_BIT_A0] <= eq_reg.down_usb_eq_b0[0];
        end
    end

    // hot plug low timer; restarts whenever the input is high
    logic [CNT_W-1:0] hpd_cnt_reg;
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            hpd_cnt_reg <= '0;
        end else if (hpd_s || !run_reg) begin
            hpd_cnt_reg <= '0;
        end else if (hpd_cnt_reg != CNT_W'(HPD_TIMEOUT_CYC)) begin
            hpd_cnt_reg <= hpd_cnt_reg + CNT_W'(1);
        end
    end
    // "longer than" the limit: expired once the count equals the limit
    logic hpd_expired;
    assign hpd_expired = (hpd_cnt_reg == CNT_W'(HPD_TIMEOUT_CYC)) && !hpd_s;

    // route selection
    logic vid_en;
    logic usb_en;
    xpt_ctrl_pkg::route_type route_next;
    assign vid_en = pin_mode ? altctl_s : ser_vid_s;
    assign usb_en = pin_mode ? usbctl_s : ser_usb_s;
    always_comb begin
        if (!run_reg) begin
            route_next = xpt_ctrl_pkg::ROUTE_OFF;
        end else begin
            unique case ({vid_en, usb_en})
                2'b01: route_next = xpt_ctrl_pkg::ROUTE_USB;
                2'b11: route_next = xpt_ctrl_pkg::ROUTE_USB_DP2;
                2'b10: route_next = xpt_ctrl_pkg::ROUTE_DP4;
                2'b00: route_next = xpt_ctrl_pkg::ROUTE_OFF;
            endcase
        end
    end

    // registered routing
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            route_o <= xpt_ctrl_pkg::ROUTE_OFF;
        end else begin
            route_o <= route_next;
        end
    end

    // lane enables, aux switch and orientation
    logic flip;
    assign flip = pin_mode ? orient_s : flip2_reg;
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            lane_ctl_o <= '0;
        end else begin
            unique case (route_next)
                xpt_ctrl_pkg::ROUTE_DP4: lane_ctl_o.video_lane_en <= xpt_ctrl_pkg::LANES_ALL;
                xpt_ctrl_pkg::ROUTE_USB_DP2: lane_ctl_o.video_lane_en <= xpt_ctrl_pkg::LANES_LOW2;
                default: lane_ctl_o.video_lane_en <= xpt_ctrl_pkg::LANES_OFF;
            endcase
            if (hpd_expired) begin
                lane_ctl_o.video_lane_en <= xpt_ctrl_pkg::LANES_OFF;
            end
            lane_ctl_o.up_usb_en <= (route_next == xpt_ctrl_pkg::ROUTE_USB)
                || (route_next == xpt_ctrl_pkg::ROUTE_USB_DP2);
            lane_ctl_o.down_usb_en <= (route_next == xpt_ctrl_pkg::ROUTE_USB)
                || (route_next == xpt_ctrl_pkg::ROUTE_USB_DP2);
            // both tx pairs carry video only in four-lane routing
            lane_ctl_o.tx_pairs_are_inputs <= (route_next == xpt_ctrl_pkg::ROUTE_DP4);
            // aux stays closed even after a hot plug timeout
            lane_ctl_o.aux_sbu_closed <= (route_next == xpt_ctrl_pkg::ROUTE_DP4)
                || (route_next == xpt_ctrl_pkg::ROUTE_USB_DP2);
            lane_ctl_o.aux_swap <= flip;
        end
    end

    // timeout flag for observation
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            hpd_timed_out_o <= 1'b0;
        end else begin
            hpd_timed_out_o <= hpd_expired;
        end
    end

    // gain code: two four-level straps form a 4-bit index
    function automatic logic [3:0] gain_of(input logic [1:0] b1, input logic [1:0] b0);
        gain_of = {b1, b0};
    endfunction

    // equalizer gains from latched straps
    logic [3:0] up_raw;
    // both upstream straps, each a full four-level code
    assign up_raw = gain_of(eq_reg.up_usb_eq_b1, eq_reg.up_usb_eq_b0);
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            eq_gain_o <= '0;
        end else begin
            // cap the upstream path rather than wrap
            eq_gain_o.up_gain <= (up_raw > xpt_ctrl_pkg::UP_GAIN_MAX_CODE)
                ? xpt_ctrl_pkg::UP_GAIN_MAX_CODE : up_raw;
            eq_gain_o.down_gain <= gain_of(eq_reg.down_usb_eq_b1, eq_reg.down_usb_eq_b0);
            eq_gain_o.video_gain <= gain_of(eq_reg.video_eq_b1, eq_reg.video_eq_b0);
        end
    end

endmodule

// ===== verif/xpt_ctrl_assertions.sv
// assertion checker for the crosspoint control block
`timescale 1ns/1ps
module xpt_ctrl_assertions #(
    parameter int HPD_TIMEOUT_CYC = 20
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic dev_en_i,
    input wire logic altmode_ctl_i,
    input wire logic usb_ctl_or_serial_data_i,
    input wire logic orient_or_serial_clk_i,
    input wire logic hot_plug_in_i,
    input wire logic serial_en_o,
    input wire logic serial_1v8_o,
    input wire logic test_mode_o,
    input wire logic serial_clk_o,
    input wire logic serial_data_o,
    input wire xpt_ctrl_pkg::route_type route_o,
    input wire xpt_ctrl_pkg::lane_ctl_type lane_ctl_o,
    input wire xpt_ctrl_pkg::eq_gain_type eq_gain_o,
    input wire logic hpd_timed_out_o
);
    int low_cnt; // cycles of hot plug low while enabled
    int calm_cnt; // cycles enabled with control pins unchanged
    xpt_ctrl_pkg::route_type pin_route; // routing the two control pins ask for
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    // run lengths; low_cnt saturates so a long run cannot wrap, calm_cnt does not
    always_ff @(posedge mclk_i) begin
        low_cnt <= (!rst_b_i || hot_plug_in_i || !dev_en_i) ? 0 : low_cnt + (low_cnt < 9999);
        calm_cnt <= (!rst_b_i || !dev_en_i || altmode_ctl_i != $past(altmode_ctl_i)
            || usb_ctl_or_serial_data_i != $past(usb_ctl_or_serial_data_i)) ? 0 : calm_cnt + 1;
    end
    assign pin_route = !altmode_ctl_i ? (usb_ctl_or_serial_data_i ? xpt_ctrl_pkg::ROUTE_USB
        : xpt_ctrl_pkg::ROUTE_OFF) : (usb_ctl_or_serial_data_i ? xpt_ctrl_pkg::ROUTE_USB_DP2
        : xpt_ctrl_pkg::ROUTE_DP4);
    property p_ser_levels;
        serial_1v8_o || test_mode_o |-> serial_en_o && !(serial_1v8_o && test_mode_o);
    endproperty
    a_ser_levels: assert property (p_ser_levels) else $error("level flag wrong");
    property p_clk_pass;
        serial_en_o && $past(serial_en_o, 3) |-> serial_clk_o == $past(orient_or_serial_clk_i, 3);
    endproperty
    a_clk_pass: assert property (p_clk_pass) else $error("serial clock not passed");
    property p_data_pass;
        serial_en_o && $past(serial_en_o, 3)
            |-> serial_data_o == $past(usb_ctl_or_serial_data_i, 3);
    endproperty
    a_data_pass: assert property (p_data_pass) else $error("serial data not passed");
    property p_pin_idle;
        !serial_en_o && $past(!serial_en_o, 3) |-> serial_clk_o && serial_data_o;
    endproperty
    a_pin_idle: assert property (p_pin_idle) else $error("serial lines not idle");
    property p_hpd_early;
        $rose(hpd_timed_out_o) |-> low_cnt >= HPD_TIMEOUT_CYC;
    endproperty
    a_hpd_early: assert property (p_hpd_early) else $error("hot plug timeout too soon");
    property p_hpd_late;
        low_cnt == HPD_TIMEOUT_CYC + 8 |-> hpd_timed_out_o;
    endproperty
    a_hpd_late: assert property (p_hpd_late) else $error("hot plug timeout missing");
    property p_hpd_lanes;
        hpd_timed_out_o && $past(hpd_timed_out_o)
            |-> lane_ctl_o.video_lane_en == xpt_ctrl_pkg::LANES_OFF && lane_ctl_o.aux_sbu_closed;
    endproperty
    a_hpd_lanes: assert property (p_hpd_lanes) else $error("lanes wrong after timeout");
    property p_hpd_back;
        hot_plug_in_i [*6] |-> !hpd_timed_out_o;
    endproperty
    a_hpd_back: assert property (p_hpd_back) else $error("timeout held with plug high");
    property p_off;
        !dev_en_i [*5] |-> route_o == xpt_ctrl_pkg::ROUTE_OFF;
    endproperty
    a_off: assert property (p_off) else $error("routing while disabled");
    property p_pin_route;
        calm_cnt >= 6 && $stable(altmode_ctl_i) && $stable(usb_ctl_or_serial_data_i)
            && !serial_en_o && !hpd_timed_out_o |-> route_o == pin_route;
    endproperty
    a_pin_route: assert property (p_pin_route) else $error("pin routing wrong");
    property p_gain_cap;
        eq_gain_o.up_gain <= xpt_ctrl_pkg::UP_GAIN_MAX_CODE;
    endproperty
    a_gain_cap: assert property (p_gain_cap) else $error("upstream gain over cap");
endmodule

// ===== verif/xpt_sink_model.sv
// far side model: video sink hot plug and board strap wiring
`timescale 1ns/1ps
module xpt_sink_model (
    // clock
    input wire logic mclk_i,
    // scenario controls
    input wire logic plugged_i,
    input wire logic sel_1v8_i,
    input wire logic [11:0] eq_pick_i,
    // toward the block
    output logic hot_plug_o = 1'h1,
    output xpt_ctrl_pkg::eq_straps_type eq_straps_o
);
    // sink hot plug is a clean level launched from its own clock
    always_ff @(posedge mclk_i) begin
        hot_plug_o <= plugged_i;
    end
    // a board at 1.8V serial levels ties the downstream usb eq bit0 strap to zero
    always_comb begin
        eq_straps_o = eq_pick_i;
        if (sel_1v8_i) begin
            eq_straps_o.down_usb_eq_b0 = 2'h0;
        end
    end
endmodule

// ===== verif/tb_alt_mode_crosspoint_control.sv
// testbench for the crosspoint control block
`timescale 1ns/1ps
module tb_alt_mode_crosspoint_control;
    localparam int HPD_CYC = 20; // shortened hot plug timeout
    logic mclk_i = 1'h0, rst_b_i = 1'h0, dev_en_i = 1'h0, plugged = 1'h1;
    logic orient = 1'h0, usb_ctl = 1'h0, altmode = 1'h0;
    logic ser_video = 1'h0, ser_usb = 1'h0, ser_flip = 1'h0;
    logic [1:0] prog_sel_i = 2'h0;
    logic [11:0] eq_pick = 12'h000;
    logic hot_plug, serial_en, serial_1v8, test_mode, serial_clk, serial_data, timed_out;
    logic [6:0] addr;
    xpt_ctrl_pkg::eq_straps_type straps;
    xpt_ctrl_pkg::route_type route;
    xpt_ctrl_pkg::lane_ctl_type lane;
    xpt_ctrl_pkg::eq_gain_type gain;
    int fails = 0, samples_checked = 0, cyc = 0;
    xpt_ctrl #(.HPD_TIMEOUT_CYC(HPD_CYC)) xpt_ctrl_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .dev_en_i(dev_en_i), .prog_sel_i(prog_sel_i), .eq_straps_i(straps),
        .orient_or_serial_clk_i(orient), .usb_ctl_or_serial_data_i(usb_ctl),
        .altmode_ctl_i(altmode), .hot_plug_in_i(hot_plug), .ser_video_en_i(ser_video),
        .ser_usb_en_i(ser_usb), .ser_flip_i(ser_flip), .serial_en_o(serial_en),
        .serial_1v8_o(serial_1v8), .test_mode_o(test_mode), .serial_clk_o(serial_clk),
        .serial_data_o(serial_data), .target_addr_o(addr), .route_o(route),
        .lane_ctl_o(lane), .eq_gain_o(gain), .hpd_timed_out_o(timed_out));
    xpt_sink_model xpt_sink_model_i (.mclk_i(mclk_i), .plugged_i(plugged),
        .sel_1v8_i(prog_sel_i == 2'h2), .eq_pick_i(eq_pick), .hot_plug_o(hot_plug),
        .eq_straps_o(straps));
    initial begin
        forever #20 mclk_i = ~mclk_i;
    end
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    // straps only latch on a fresh enable, so drop it around every change
    task automatic cfg(input logic [1:0] sel, input logic [11:0] eq);
        dev_en_i <= 1'h0;
        tick(4);
        prog_sel_i <= sel;
        eq_pick <= eq;
        tick(2);
        dev_en_i <= 1'h1;
        tick(8);
    endtask
    task automatic t_pin();
        xpt_ctrl_pkg::route_type exp_r [4];
        exp_r = '{xpt_ctrl_pkg::ROUTE_OFF, xpt_ctrl_pkg::ROUTE_USB, xpt_ctrl_pkg::ROUTE_DP4,
            xpt_ctrl_pkg::ROUTE_USB_DP2};
        cfg(2'h0, 12'h000);
        for (int i = 0; i < 4; i++) begin
            altmode <= i[1];
            usb_ctl <= i[0];
            orient <= i[0];
            tick(6);
            chk(route, exp_r[i]);
            chk(serial_en, 1'h0);
            if (i[0] ^ i[1]) begin
                chk(lane.tx_pairs_are_inputs, i[1]);
                chk(lane.video_lane_en, i[1] ? 4'hf : 4'h0);
            end
        end
        chk(lane.aux_swap, 1'h1);
        orient <= 1'h0;
        tick(6);
        chk(lane.aux_swap, 1'h0);
        $display("test pin routing done");
    endtask
    task automatic t_serial();
        for (int s = 1; s < 4; s++) begin
            altmode <= 1'h1;
            ser_usb <= 1'h1;
            ser_video <= 1'h0;
            ser_flip <= s[0];
            cfg(s[1:0], 12'hf11);
            chk(gain, {4'hb, 3'h0, s != 2, 4'h1});
            chk(lane.aux_swap, s[0]);
            chk(serial_en, 1'h1);
            chk(serial_1v8, s == 2);
            chk(test_mode, s == 1);
            chk(addr, {xpt_ctrl_pkg::ADDR_BASE[6:2], 1'h1, s != 2});
            chk(route, xpt_ctrl_pkg::ROUTE_USB);
            orient <= 1'h1;
            usb_ctl <= 1'h0;
            eq_pick <= 12'h000;
            ser_video <= 1'h1;
            tick(6);
            chk(serial_clk, 1'h1);
            chk(serial_data, 1'h0);
            chk(route, xpt_ctrl_pkg::ROUTE_USB_DP2);
            chk(gain, {4'hb, 3'h0, s != 2, 4'h1});
            chk(addr, {xpt_ctrl_pkg::ADDR_BASE[6:2], 1'h1, s != 2});
        end
        $display("test serial modes done");
    endtask
    task automatic t_hpd();
        cfg(2'h0, 12'h000);
        altmode <= 1'h1;
        usb_ctl <= 1'h1;
        tick(6);
        plugged <= 1'h0;
        tick(HPD_CYC - 4);
        chk(timed_out, 1'h0);
        tick(14);
        chk(timed_out, 1'h1);
        chk(lane.video_lane_en, 4'h0);
        chk(lane.aux_sbu_closed, 1'h1);
        plugged <= 1'h1;
        tick(8);
        chk(timed_out, 1'h0);
        chk(lane.video_lane_en, 4'h3);
        $display("test hot plug timeout done");
    endtask
    task automatic finish_test();
        $display("checked %0d failed %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // hang guard, far above the under two hundred cycles the tests need
    initial begin
        forever begin
            @(posedge mclk_i);
            cyc++;
            if (cyc == 3000) begin
                fails++;
                finish_test();
            end
        end
    end
    initial begin
        tick(5);
        rst_b_i <= 1'h1;
        tick(2);
        chk(serial_clk, 1'h1);
        chk(addr, xpt_ctrl_pkg::ADDR_BASE);
        chk(route, xpt_ctrl_pkg::ROUTE_OFF);
        t_pin();
        t_serial();
        t_hpd();
        finish_test();
    end
endmodule
bind xpt_ctrl xpt_ctrl_assertions #(.HPD_TIMEOUT_CYC(HPD_TIMEOUT_CYC)) xpt_ctrl_assertions_i (
    .mclk_i, .rst_b_i, .dev_en_i, .altmode_ctl_i, .usb_ctl_or_serial_data_i,
    .orient_or_serial_clk_i, .hot_plug_in_i, .serial_en_o, .serial_1v8_o, .test_mode_o,
    .serial_clk_o, .serial_data_o, .route_o, .lane_ctl_o, .eq_gain_o, .hpd_timed_out_o);
